// >>> design/scfg_defs.vh
// Constants for the synthesizer configuration register decode block
`ifndef SCFG_DEFS_VH
`define SCFG_DEFS_VH

// Select codes carried in the low three bits of each word
`define SCFG_SEL_LSB 0
`define SCFG_SEL_MSB 2
`define SCFG_SEL_DBUF 3'h2
`define SCFG_SEL_LOCK_SPEED 3'h3
`define SCFG_SEL_OUT_STAGE 3'h4
`define SCFG_SEL_LOCK_PIN 3'h5

// Avalon word addresses (byte address = 4 x index)
`define SCFG_ADDR_WORD 4'h0
`define SCFG_ADDR_LOCK_SPEED 4'h3
`define SCFG_ADDR_OUT_STAGE 4'h4
`define SCFG_ADDR_LOCK_PIN 4'h5
`define SCFG_ADDR_STATUS 4'h8

// Second word: double buffer enable
`define SCFG_DBUF_BIT 13

// Third word fields
`define SCFG_ABP_BIT 22
`define SCFG_CCAN_BIT 21
`define SCFG_CSR_BIT 18
`define SCFG_CDM_MSB 16
`define SCFG_CDM_LSB 15
`define SCFG_CDV_MSB 14
`define SCFG_CDV_LSB 3

// Clock divider modes
`define SCFG_CDM_OFF 2'h0
`define SCFG_CDM_FASTLOCK 2'h1
`define SCFG_CDM_RESYNC 2'h2

// Fourth word fields
`define SCFG_FBSEL_BIT 23
`define SCFG_DIV_MSB 22
`define SCFG_DIV_LSB 20
`define SCFG_BSC_MSB 19
`define SCFG_BSC_LSB 12
`define SCFG_VCOPD_BIT 11
`define SCFG_MUTE_BIT 10
`define SCFG_AUXSEL_BIT 9
`define SCFG_AUXEN_BIT 8
`define SCFG_AUXPWR_MSB 7
`define SCFG_AUXPWR_LSB 6
`define SCFG_OUTEN_BIT 5
`define SCFG_OUTPWR_MSB 4
`define SCFG_OUTPWR_LSB 3

// Sixth word fields
`define SCFG_LDPIN_MSB 23
`define SCFG_LDPIN_LSB 22

// Reset values
`define SCFG_RESET_WORD 32'h0

// Anti-backlash widths in ns
`define SCFG_ABP_WIDE_NS 4'h6
`define SCFG_ABP_NARROW_NS 4'h3

`endif

// >>> design/scfg_register_decode.v
// Configuration register decode for a fractional-N synthesizer
//
// Function
// RULE1: Bit 22 of third word picks 6 ns (0) or 3 ns (1) backlash pulse.
// RULE2: Bit 21 of third word enables charge cancellation; host keeps 0 fractional.
// RULE3: Bit 18 of third word enables cycle slip reduction.
// RULE4: Host using slip reduction ensures 50% duty and minimum pump current.
// RULE5: Bits 16:15 select resync (10), fast lock (01), or off (00).
// RULE6: Bits 14:3 are the 12-bit timeout for resync and fast lock.
// RULE7: Select code 100 loads the fourth register.
// RULE8: Select code 101 loads the sixth register.
// RULE9: Bit 23 of fourth word feeds back from oscillator (1) or divider (0).
// RULE10: Bits 22:20 of fourth word choose the output divider ratio.
// RULE11: Bits 19:12 divide the reference clock for band select logic.
// RULE12: Bit 11 of fourth word powers the oscillator down.
// RULE13: Bit 10 mutes output stage supply until digital lock.
// RULE14: Bit 9 routes auxiliary output from divider (0) or oscillator (1).
// RULE15: Bit 8 enables the auxiliary output.
// RULE16: Bits 7:6 choose auxiliary output power.
// RULE17: Bit 5 enables the primary output.
// RULE18: Bits 4:3 choose primary output power.
// RULE19: Bits 23:22 of sixth word select the lock indicator pin function.
// RULE20: Host writes words after power-up from register five down to zero.
// RULE21: Host keeps modulus 2..4095, numerator below modulus, reference 1..1023.
// RULE22: Host keeps comparison rate under 32 MHz fractional, 90 MHz integer.
// RULE23: Select code 011 loads the third register.
// RULE24: Second word bit 13 double-buffers the output divider field.
// RULE25: Host keeps band select divider at most 254 in fast band mode.
// RULE26: Select code comes from low three bits; only that register updates.
`timescale 1ns/1ns
`default_nettype none
`include "scfg_defs.vh"

module scfg_register_decode (
    // Clock and reset
    input wire clk_sys,
    input wire reset_n,
    // Avalon-MM slave
    input wire [3:0] avs_address,
    input wire avs_write,
    input wire avs_read,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    // Lock event from the digital lock detector, same clock
    input wire lock_detected,
    // Reload strobe for the double-buffered divider, same clock
    input wire divider_reload,
    // Third word controls
    output reg antibacklash_width_sel,
    output reg [3:0] antibacklash_ns,
    output reg charge_cancel_en,
    output reg slip_reduction_en,
    output reg resync_en,
    output reg fast_lock_en,
    output reg [11:0] clock_divider_timeout,
    // Fourth word controls
    output reg feedback_from_osc,
    output reg [2:0] output_freq_divider,
    output reg [7:0] band_select_divider,
    output reg osc_power_down,
    output reg mute_until_locked,
    output reg output_stage_supply_en,
    output reg aux_from_osc,
    output reg aux_out_en,
    output reg [1:0] aux_out_power,
    output reg primary_out_en,
    output reg [1:0] primary_out_power,
    // Sixth word control
    output reg [1:0] lock_indicator_pin
);

// ----------------------------------------------------------------
// Register storage
// ----------------------------------------------------------------
reg [31:0] lock_speed_config_reg;
reg [31:0] output_stage_config_reg;
reg [31:0] lock_pin_config_reg;
reg double_buffer_en_reg;
reg [2:0] divider_active_reg;
reg locked_reg;
reg read_ready_reg;

wire [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                       {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
wire [2:0] word_sel = avs_writedata[`SCFG_SEL_MSB:`SCFG_SEL_LSB]; // RULE26
wire word_wr = avs_write && (avs_address == `SCFG_ADDR_WORD);
wire sel_third = word_wr && (word_sel == `SCFG_SEL_LOCK_SPEED); // RULE23
wire sel_fourth = word_wr && (word_sel == `SCFG_SEL_OUT_STAGE); // RULE7
wire sel_sixth = word_wr && (word_sel == `SCFG_SEL_LOCK_PIN); // RULE8
wire sel_dbuf = word_wr && (word_sel == `SCFG_SEL_DBUF);

// Writes finish at once; a read waits one cycle so its registered data stands
assign avs_waitrequest = avs_read && !read_ready_reg;

// ----------------------------------------------------------------
// Word writes
// ----------------------------------------------------------------
// Words arrive whole; byte enables apply only to direct-address writes
always @(posedge clk_sys) begin
    if (!reset_n) begin
        lock_speed_config_reg <= `SCFG_RESET_WORD;
        output_stage_config_reg <= `SCFG_RESET_WORD;
        lock_pin_config_reg <= `SCFG_RESET_WORD;
        double_buffer_en_reg <= 1'b0;
    end else begin
        if (sel_third) begin
            lock_speed_config_reg <= avs_writedata; // RULE26
        end else if (avs_write && avs_address == `SCFG_ADDR_LOCK_SPEED) begin
            lock_speed_config_reg <= (lock_speed_config_reg & ~be_mask)
                | (avs_writedata & be_mask);
        end
        if (sel_fourth) begin
            output_stage_config_reg <= avs_writedata; // RULE26
        end else if (avs_write && avs_address == `SCFG_ADDR_OUT_STAGE) begin
            output_stage_config_reg <= (output_stage_config_reg & ~be_mask)
                | (avs_writedata & be_mask);
        end
        if (sel_sixth) begin
            lock_pin_config_reg <= avs_writedata; // RULE26
        end else if (avs_write && avs_address == `SCFG_ADDR_LOCK_PIN) begin
            lock_pin_config_reg <= (lock_pin_config_reg & ~be_mask)
                | (avs_writedata & be_mask);
        end
        if (sel_dbuf) begin
            double_buffer_en_reg <= avs_writedata[`SCFG_DBUF_BIT]; // RULE24
        end
    end
end

// ----------------------------------------------------------------
// Divider double buffering and lock tracking
// ----------------------------------------------------------------
// Buffered divider waits for the reload strobe so a retune lands at once
always @(posedge clk_sys) begin
    if (!reset_n) begin
        divider_active_reg <= 3'h0;
        locked_reg <= 1'b0;
    end else begin
        if (!double_buffer_en_reg || divider_reload) begin
            divider_active_reg <=
                output_stage_config_reg[`SCFG_DIV_MSB:`SCFG_DIV_LSB]; // RULE24
        end
        // A new fourth word restarts the wait for lock; a lock event wins
        if (lock_detected) begin
            locked_reg <= 1'b1;
        end else if (sel_fourth) begin
            locked_reg <= 1'b0;
        end
    end
end

// ----------------------------------------------------------------
// Field outputs
// ----------------------------------------------------------------
always @(posedge clk_sys) begin
    if (!reset_n) begin
        antibacklash_width_sel <= 1'b0;
        antibacklash_ns <= `SCFG_ABP_WIDE_NS;
        charge_cancel_en <= 1'b0;
        slip_reduction_en <= 1'b0;
        resync_en <= 1'b0;
        fast_lock_en <= 1'b0;
        clock_divider_timeout <= 12'h000;
        feedback_from_osc <= 1'b0;
        output_freq_divider <= 3'h0;
        band_select_divider <= 8'h00;
        osc_power_down <= 1'b0;
        mute_until_locked <= 1'b0;
        output_stage_supply_en <= 1'b0;
        aux_from_osc <= 1'b0;
        aux_out_en <= 1'b0;
        aux_out_power <= 2'h0;
        primary_out_en <= 1'b0;
        primary_out_power <= 2'h0;
        lock_indicator_pin <= 2'h0;
    end else begin
        antibacklash_width_sel <= lock_speed_config_reg[`SCFG_ABP_BIT]; // RULE1
        antibacklash_ns <= lock_speed_config_reg[`SCFG_ABP_BIT]
            ? `SCFG_ABP_NARROW_NS : `SCFG_ABP_WIDE_NS; // RULE1
        charge_cancel_en <= lock_speed_config_reg[`SCFG_CCAN_BIT]; // RULE2
        slip_reduction_en <= lock_speed_config_reg[`SCFG_CSR_BIT]; // RULE3
        resync_en <= (lock_speed_config_reg[`SCFG_CDM_MSB:`SCFG_CDM_LSB]
            == `SCFG_CDM_RESYNC); // RULE5
        fast_lock_en <= (lock_speed_config_reg[`SCFG_CDM_MSB:`SCFG_CDM_LSB]
            == `SCFG_CDM_FASTLOCK); // RULE5
        clock_divider_timeout <=
            lock_speed_config_reg[`SCFG_CDV_MSB:`SCFG_CDV_LSB]; // RULE6
        feedback_from_osc <= output_stage_config_reg[`SCFG_FBSEL_BIT]; // RULE9
        // Same latency as the other fields when buffering is off or reloading
        if (!double_buffer_en_reg || divider_reload) begin
            output_freq_divider <=
                output_stage_config_reg[`SCFG_DIV_MSB:`SCFG_DIV_LSB]; // RULE10 RULE24
        end else begin
            output_freq_divider <= divider_active_reg; // RULE24
        end
        band_select_divider <=
            output_stage_config_reg[`SCFG_BSC_MSB:`SCFG_BSC_LSB]; // RULE11
        osc_power_down <= output_stage_config_reg[`SCFG_VCOPD_BIT]; // RULE12
        mute_until_locked <= output_stage_config_reg[`SCFG_MUTE_BIT]; // RULE13
        output_stage_supply_en <= !output_stage_config_reg[`SCFG_MUTE_BIT]
            || locked_reg; // RULE13
        aux_from_osc <= output_stage_config_reg[`SCFG_AUXSEL_BIT]; // RULE14
        aux_out_en <= output_stage_config_reg[`SCFG_AUXEN_BIT]; // RULE15
        aux_out_power <=
            output_stage_config_reg[`SCFG_AUXPWR_MSB:`SCFG_AUXPWR_LSB]; // RULE16
        primary_out_en <= output_stage_config_reg[`SCFG_OUTEN_BIT]; // RULE17
        primary_out_power <=
            output_stage_config_reg[`SCFG_OUTPWR_MSB:`SCFG_OUTPWR_LSB]; // RULE18
        lock_indicator_pin <=
            lock_pin_config_reg[`SCFG_LDPIN_MSB:`SCFG_LDPIN_LSB]; // RULE19
    end
end

// ----------------------------------------------------------------
// Read path
// ----------------------------------------------------------------
// Config words are write-only on the device; readback here aids bring-up
always @(posedge clk_sys) begin
    if (!reset_n) begin
        avs_readdata <= 32'h0;
        read_ready_reg <= 1'b0;
    end else begin
        read_ready_reg <= avs_read && !read_ready_reg;
        if (avs_read && !read_ready_reg) begin
        case (avs_address)
            `SCFG_ADDR_LOCK_SPEED: avs_readdata <= lock_speed_config_reg;
            `SCFG_ADDR_OUT_STAGE: avs_readdata <= output_stage_config_reg;
            `SCFG_ADDR_LOCK_PIN: avs_readdata <= lock_pin_config_reg;
            `SCFG_ADDR_STATUS: avs_readdata <= {26'h0, double_buffer_en_reg,
                divider_active_reg, output_stage_supply_en, locked_reg};
            default: avs_readdata <= 32'h0;
        endcase
        end
    end
end

endmodule // scfg_register_decode
`default_nettype wire

// >>> dv/scfg_chk.sv
// Assertion checker for the configuration register decode
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// Checker
// ------------------------------------------------------------
module scfg_chk (
    // Clock, reset, bus
    input wire logic clk_sys, reset_n, avs_write, lock_detected,
    input wire logic [3:0] avs_address,
    input wire logic [31:0] avs_writedata,
    // Field outputs
    input wire logic antibacklash_width_sel, charge_cancel_en, slip_reduction_en,
    input wire logic resync_en, fast_lock_en, feedback_from_osc, osc_power_down,
    input wire logic mute_until_locked, output_stage_supply_en, aux_from_osc,
    input wire logic aux_out_en, primary_out_en,
    input wire logic [3:0] antibacklash_ns,
    input wire logic [11:0] clock_divider_timeout,
    input wire logic [7:0] band_select_divider,
    input wire logic [1:0] aux_out_power, primary_out_power, lock_indicator_pin
);
    logic [31:0] d1, d2;
    wire logic w = avs_write && avs_address == 4'h0;
    wire logic [2:0] s = avs_writedata[2:0];
    // Data delayed to line up with the two-cycle field latency
    always @(posedge clk_sys) begin
        d1 <= avs_writedata;
        d2 <= d1;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    a_abp_width: assert property (w && s == 3'h3 |-> ##2
        antibacklash_width_sel == d2[22] && antibacklash_ns == (d2[22] ? 4'h3 : 4'h6))
        else $error("antibacklash width wrong");
    a_charge_cancel: assert property (w && s == 3'h3 |-> ##2 charge_cancel_en == d2[21])
        else $error("charge cancel wrong");
    a_slip_reduce: assert property (w && s == 3'h3 |-> ##2 slip_reduction_en == d2[18])
        else $error("slip reduction wrong");
    a_divider_mode: assert property (w && s == 3'h3 |-> ##2
        resync_en == (d2[16:15] == 2'h2) && fast_lock_en == (d2[16:15] == 2'h1))
        else $error("clock divider mode wrong");
    a_timeout_value: assert property (w && s == 3'h3 |-> ##2
        clock_divider_timeout == d2[14:3]) else $error("timeout value wrong");
    a_out_stage: assert property (w && s == 3'h4 |-> ##2
        {feedback_from_osc, band_select_divider, osc_power_down, mute_until_locked, aux_from_osc,
        aux_out_en, aux_out_power, primary_out_en, primary_out_power} == {d2[23], d2[19:3]})
        else $error("output stage fields wrong");
    a_lock_pin: assert property (w && s == 3'h5 |-> ##2 lock_indicator_pin == d2[23:22])
        else $error("lock pin field wrong");
    a_unmute_lock: assert property (mute_until_locked && lock_detected |-> ##[1:3]
        output_stage_supply_en) else $error("supply not restored on lock");
    a_sel_ignore: assert property (w && (s < 3'h2 || s > 3'h5) |-> ##2
        $stable(lock_indicator_pin) && $stable(antibacklash_ns) && $stable(band_select_divider))
        else $error("ignored word changed a field");
    c_lock_speed: cover property (w && s == 3'h3);
    c_out_stage: cover property (w && s == 3'h4);
    c_lock_seen: cover property (mute_until_locked && lock_detected);
endmodule // scfg_chk
bind scfg_register_decode scfg_chk u_chk (.*);
`default_nettype wire

// >>> dv/scfg_host_model.sv
// Host controller model that writes configuration words
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// Host model
// ------------------------------------------------------------
module scfg_host_model (
    // Bench request
    input wire logic clk_sys, reset_n, req, avs_waitrequest,
    input wire logic [31:0] word,
    // Avalon-MM master side
    output logic done = 1'b0,
    output logic avs_write = 1'b0,
    output logic avs_read,
    output logic [3:0] avs_address, avs_byteenable,
    output logic [31:0] avs_writedata = 32'h0
);
    // All words use the word port; their low bits pick the target
    assign avs_address = 4'h0;
    assign avs_read = 1'b0;
    assign avs_byteenable = 4'hF;
    always @(posedge clk_sys) begin
        done <= 1'b0;
        if (!reset_n) begin
            avs_write <= 1'b0;
        end else if (avs_write && !avs_waitrequest) begin
            // Released data is inverted so a stale word never looks valid
            avs_write <= 1'b0;
            avs_writedata <= ~avs_writedata;
            done <= 1'b1;
        end else if (req && !avs_write) begin
            avs_write <= 1'b1;
            avs_writedata <= word;
        end
    end
endmodule // scfg_host_model
`default_nettype wire

// >>> dv/tb_top.sv
// Testbench for the configuration register decode
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// Bench
// ------------------------------------------------------------
module tb_top;
    logic clk_sys = 1'b0, reset_n = 1'b0, req = 1'b0, lock_detected = 1'b0, lk = 1'b0;
    logic divider_reload = 1'b0, done, avs_write, avs_read, avs_waitrequest;
    logic [31:0] word = 32'h0, e3 = 32'h0, e4 = 32'h0, e5 = 32'h0, avs_writedata, avs_readdata;
    logic [3:0] avs_address, avs_byteenable, antibacklash_ns;
    logic [11:0] clock_divider_timeout;
    logic [7:0] band_select_divider;
    logic [2:0] output_freq_divider;
    logic [1:0] aux_out_power, primary_out_power, lock_indicator_pin;
    logic antibacklash_width_sel, charge_cancel_en, slip_reduction_en, resync_en, fast_lock_en;
    logic feedback_from_osc, osc_power_down, mute_until_locked, output_stage_supply_en;
    logic aux_from_osc, aux_out_en, primary_out_en;
    logic [2:0] sels [7] = '{3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h3, 3'h4};
    logic [2:0] ediv = 3'h0;
    logic dbuf = 1'b0;
    int n_fail = 0, cmp_count = 0;
    always #2 clk_sys = ~clk_sys;
    scfg_register_decode DUT (.*);
    scfg_host_model u_host (.*);
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function logic [31:0] mk(input logic [2:0] s);
        logic [31:0] r;
        r = $urandom();
        return {r[31:3], s};
    endfunction
    // Compare after the edge's updates land, then realign to an edge
    task settle;
        #1;
        chk(antibacklash_ns, e3[22] ? 4'h3 : 4'h6);
        chk({antibacklash_width_sel, charge_cancel_en}, e3[22:21]);
        chk(slip_reduction_en, e3[18]);
        chk({resync_en, fast_lock_en}, {e3[16:15] == 2'h2, e3[16:15] == 2'h1});
        chk(clock_divider_timeout, e3[14:3]);
        chk(feedback_from_osc, e4[23]);
        chk(output_freq_divider, ediv);
        chk({band_select_divider, osc_power_down}, e4[19:11]);
        chk({mute_until_locked, output_stage_supply_en}, {e4[10], !e4[10] | lk});
        chk({aux_from_osc, aux_out_en, aux_out_power}, e4[9:6]);
        chk({primary_out_en, primary_out_power}, e4[5:3]);
        chk(lock_indicator_pin, e5[23:22]);
        @(posedge clk_sys);
    endtask
    task wr(input logic [31:0] w);
        int n;
        n = 0;
        req <= 1'b1;
        word <= w;
        @(posedge clk_sys);
        req <= 1'b0;
        divider_reload <= 1'($urandom_range(1));
        do @(posedge clk_sys); while (done !== 1'b1 && ++n < 20);
        if (n >= 20) n_fail++;
        case (w[2:0])
            3'h3: e3 = w;
            3'h2: begin
                dbuf = w[13];
                if (!dbuf) ediv = e4[22:20];
            end
            3'h4: begin
                e4 = w;
                lk = 1'b0;
                if (!dbuf || divider_reload) ediv = w[22:20];
            end
            3'h5: e5 = w;
            default: ;
        endcase
        settle;
    endtask
    task results;
        $display("comparisons=%0d failures=%0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #20000;
        n_fail++;
        results;
    end
    initial begin
        void'($urandom(32'h1f16));
        repeat (3) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        settle;
        for (int i = 5; i >= 3; i--) wr(mk(3'(i)));
        for (int i = 0; i < 3; i++) wr({15'h0, 2'(i), 12'hFFF, 3'h3});
        wr(32'h00000404);
        lock_detected <= 1'b1;
        @(posedge clk_sys);
        lock_detected <= 1'b0;
        lk = 1'b1;
        repeat (3) @(posedge clk_sys);
        settle;
        wr(32'h00000404);
        wr(32'h00040003);
        wr(32'h000FE004);
        wr(32'h00002002);
        wr(mk(3'h4));
        divider_reload <= 1'b1;
        @(posedge clk_sys);
        divider_reload <= 1'b0;
        ediv = e4[22:20];
        @(posedge clk_sys);
        settle;
        wr(32'h00000002);
        // Words 0 to 2 stay out of the random mix so modulus and rates stay legal
        repeat (60) wr(mk(sels[$urandom_range(6)]));
        results;
    end
endmodule // tb_top
`default_nettype wire
